// ---- hdl/aeqc_pkg.sv ----
// Package with register layout, reset values and types of the equalizer control.
package aeqc_pkg;

  // Register offset and reset value.
  localparam logic [7:0] AEQC_CTL_OFFSET = 8'h42;
  localparam logic [7:0] AEQC_CTL_RESET  = 8'h71;

  // Field positions inside the control register.
  localparam int AEQC_RSVD_BIT   = 7;
  localparam int AEQC_ERRSEL_MSB = 6;
  localparam int AEQC_ERRSEL_LSB = 4;
  localparam int AEQC_ORDER_BIT  = 3;
  localparam int AEQC_TWOSTEP_BIT = 2;
  localparam int AEQC_NEST_BIT   = 1;
  localparam int AEQC_FILT_BIT   = 0;

  // Filter setting limits and the midpoint of the sweep.
  localparam logic [3:0] AEQC_FILT_MID = 4'h7;
  localparam logic [3:0] AEQC_FILT_TOP = 4'he;

  // Fields of the control register.
  typedef struct packed {
    logic       rsvd;
    logic [2:0] error_check_select;
    logic       filter_sweep_order;
    logic       two_step_validate_en;
    logic       loop_nesting_select;
    logic       filter_adapt_en;
  } aeqc_ctl_t;

  // Per-cycle link error strobes.
  typedef struct packed {
    logic clk_bit_err;
    logic coding_seq_err;
    logic parity_err;
  } aeqc_err_t;

  // Adaptation states, one-hot.
  typedef enum logic [3:0] {
    AEQC_IDLE  = 4'h1,
    AEQC_WAIT  = 4'h2,
    AEQC_CHECK = 4'h4,
    AEQC_STEP  = 4'h8
  } aeqc_state_t;

endpackage

// ---- hdl/aeqc_err_window.sv ----
// Error selector and counter over one accumulation window.
`timescale 1ns/10ps
module aeqc_err_window
  import aeqc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Control.
  input  wire logic [2:0]       select_in,
  input  wire aeqc_err_t        err_in,
  input  wire logic             clear_in,
  // Result.
  output logic [CNT_W-1:0]      count_out,
  output logic                  hit_out
);

  logic [CNT_W-1:0] count_q, count_d;
  logic             hit;

  // Only errors whose select bit is set are counted; none when all are clear.
  assign hit = (select_in[2] & err_in.clk_bit_err) |
               (select_in[1] & err_in.coding_seq_err) |
               (select_in[0] & err_in.parity_err);

  // Saturating count, restarted at the start of each window.
  always_comb begin
    count_d = count_q;
    if (clear_in) begin
      count_d = '0;
    end else if (hit && count_q != {CNT_W{1'b1}}) begin
      count_d = count_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;
  assign hit_out   = hit;

endmodule

// ---- hdl/aeqc_top.sv ----
// Adaptive equalizer control: register, sweep sequencer and error judge.
`timescale 1ns/10ps
module aeqc_top
  import aeqc_pkg::*;
#(
  parameter int EQ_W  = 4,
  parameter int PER_W = 16
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Register port.
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic             reg_wr_in,
  input  wire logic [7:0]       reg_wdata_in,
  output logic [7:0]            reg_rdata_out,
  // Neighbouring register values.
  input  wire logic [PER_W-1:0] relock_period_in,
  input  wire logic [7:0]       error_threshold_in,
  input  wire logic [3:0]       filter_setting_floor_in,
  input  wire logic [3:0]       filter_setting_ceiling_in,
  // Link status.
  input  wire logic             adapt_start_in,
  input  wire logic             lock_in,
  input  wire aeqc_err_t        link_err_in,
  // Settings driven to the analog front end, and the busy status.
  output logic [EQ_W-1:0]       eq_setting_out,
  output logic [3:0]            filter_setting_out,
  output logic                  adapting_out
);

  aeqc_ctl_t        ctl_q, ctl_d;
  aeqc_state_t      st_q, st_d;
  logic [PER_W-1:0] tmr_q, tmr_d;
  logic [EQ_W-1:0]  eq_q, eq_d;
  logic [3:0]       fl_q, fl_d;
  logic             busy_q, busy_d;
  logic [7:0]       rd_q, rd_d;
  logic [7:0]       err_cnt;
  logic             err_hit;
  logic             win_clr;
  logic [PER_W-1:0] half_per;
  logic [3:0]       fl_start;
  logic             eq_last, fl_last, fl_on, pass;

  // Register write and readback; reserved bit held at zero.
  always_comb begin
    ctl_d = ctl_q;
    if (reg_wr_in && reg_addr_in == AEQC_CTL_OFFSET) begin
      ctl_d = aeqc_ctl_t'(reg_wdata_in);
    end
    ctl_d.rsvd = 1'b0;
    rd_d = 8'h00;
    if (reg_addr_in == AEQC_CTL_OFFSET) begin
      rd_d = ctl_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctl_q <= aeqc_ctl_t'(AEQC_CTL_RESET);
      rd_q  <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      rd_q  <= rd_d;
    end
  end

  // Error counter over the current half-period window.
  aeqc_err_window #(
    .CNT_W (8)
  ) u_err (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .select_in (ctl_q.error_check_select),
    .err_in    (link_err_in),
    .clear_in  (win_clr),
    .count_out (err_cnt),
    .hit_out   (err_hit)
  );

  // Sweep limits and loop end detection.
  always_comb begin
    half_per = relock_period_in >> 1;
    fl_on    = ctl_q.filter_adapt_en;
    // Start at the largest delay or the midpoint, clipped to the limits.
    fl_start = ctl_q.filter_sweep_order ? AEQC_FILT_MID
                                        : filter_setting_ceiling_in;
    if (fl_start > filter_setting_ceiling_in) begin
      fl_start = filter_setting_ceiling_in;
    end
    if (fl_start < filter_setting_floor_in) begin
      fl_start = filter_setting_floor_in;
    end
    eq_last = (eq_q == {EQ_W{1'b1}});
    fl_last = !fl_on || (fl_q == filter_setting_floor_in);
  end

  // Setting is good on lock (one-step) or on an error-free window.
  always_comb begin
    if (ctl_q.two_step_validate_en) begin
      pass = (err_cnt == 8'h00) && !err_hit;
    end else begin
      pass = lock_in;
    end
  end

  // Sequencer: apply a setting, wait, judge, then step the nested loops.
  always_comb begin
    st_d    = st_q;
    tmr_d   = tmr_q;
    eq_d    = eq_q;
    fl_d    = fl_q;
    win_clr = 1'b0;
    case (st_q)
      AEQC_IDLE: begin
        // Too many errors in a window also restarts adaptation upward.
        if (adapt_start_in || (tmr_q == half_per &&
            err_cnt > error_threshold_in)) begin
          st_d    = AEQC_WAIT;
          fl_d    = fl_on ? fl_start : fl_q;
          tmr_d   = '0;
          win_clr = 1'b1;
          if (!adapt_start_in && !eq_last) begin
            eq_d = eq_q + 1'b1;
          end
        end else if (tmr_q >= half_per) begin
          tmr_d   = '0;
          win_clr = 1'b1;
        end else begin
          tmr_d = tmr_q + 1'b1;
        end
      end
      AEQC_WAIT: begin
        tmr_d = tmr_q + 1'b1;
        if (ctl_q.two_step_validate_en && tmr_q >= half_per) begin
          st_d    = AEQC_CHECK;
          tmr_d   = '0;
          win_clr = 1'b1;
        end else if (!ctl_q.two_step_validate_en &&
                     tmr_q >= relock_period_in) begin
          st_d = pass ? AEQC_IDLE : AEQC_STEP;
          tmr_d = '0;
          win_clr = 1'b1;
        end
      end
      AEQC_CHECK: begin
        tmr_d = tmr_q + 1'b1;
        if (err_hit) begin
          st_d = AEQC_STEP;
        end else if (tmr_q >= half_per) begin
          st_d    = pass ? AEQC_IDLE : AEQC_STEP;
          tmr_d   = '0;
          win_clr = 1'b1;
        end
      end
      AEQC_STEP: begin
        st_d    = AEQC_WAIT;
        tmr_d   = '0;
        win_clr = 1'b1;
        if (ctl_q.loop_nesting_select) begin
          // Filter is the inner loop.
          if (!fl_last) begin
            fl_d = fl_q - 1'b1;
          end else begin
            fl_d = fl_on ? fl_start : fl_q;
            eq_d = eq_last ? '0 : eq_q + 1'b1;
          end
        end else begin
          // Equalizer is the inner loop.
          if (!eq_last) begin
            eq_d = eq_q + 1'b1;
          end else begin
            eq_d = '0;
            if (fl_on) begin
              fl_d = fl_last ? fl_start : fl_q - 1'b1;
            end
          end
        end
      end
      default: begin
        st_d = AEQC_IDLE;
      end
    endcase
    // Busy flag is registered so the status pin comes from a flip-flop.
    busy_d = (st_d != AEQC_IDLE);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q   <= AEQC_IDLE;
      tmr_q  <= '0;
      eq_q   <= '0;
      fl_q   <= AEQC_FILT_MID;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      eq_q   <= eq_d;
      fl_q   <= fl_d;
      busy_q <= busy_d;
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata_out      = rd_q;
  assign eq_setting_out     = eq_q;
  assign filter_setting_out = fl_q;
  assign adapting_out       = busy_q;

  // A write lands whole, except the reserved bit, which stays zero.
  rsvd_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == AEQC_CTL_OFFSET) |=>
    (ctl_q == ($past(reg_wdata_in) & 8'h7f)))
    else $error("write did not land with reserved bit clear");

  // An error in the second half forces a step next cycle.
  sequence check_err_s;
    st_q == AEQC_CHECK && err_hit;
  endsequence
  two_step_adv_a: assert property (@(posedge clk_in) disable iff (rst_in)
    check_err_s |=> st_q == AEQC_STEP)
    else $error("error did not advance setting");

  // One-step judging only after the full period.
  one_step_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == AEQC_WAIT && !ctl_q.two_step_validate_en &&
     tmr_q < relock_period_in) |=> st_q == AEQC_WAIT)
    else $error("left wait early");

  // Filter stays at or under the ceiling while adapting.
  filt_limit_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == AEQC_WAIT && ctl_q.filter_adapt_en &&
     filter_setting_floor_in <= filter_setting_ceiling_in &&
     $stable(filter_setting_ceiling_in)) |-> fl_q <= filter_setting_ceiling_in)
    else $error("filter above ceiling");

  // Without filter adaptation the filter value never moves.
  filt_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!ctl_q.filter_adapt_en && !$past(ctl_q.filter_adapt_en)) |-> $stable(fl_q))
    else $error("filter moved while disabled");

  // All select bits clear means no hits.
  no_sel_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_q.error_check_select == 3'h0 |-> !err_hit)
    else $error("error counted with select clear");

  // Parity alone is counted by bit 0.
  parity_sel_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (link_err_in == 3'b001) |-> err_hit == ctl_q.error_check_select[0])
    else $error("parity select wrong");

  // Threshold crossing at window end starts a step upward.
  thold_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == AEQC_IDLE && !adapt_start_in && tmr_q == half_per &&
     err_cnt > error_threshold_in && !eq_last) |=> eq_q == $past(eq_q) + 1'b1)
    else $error("no step on threshold");

endmodule

// ---- verif/tb.sv ----
// Self-checking testbench for the adaptive equalizer control block.
`timescale 1ns/10ps
module tb;
  import aeqc_pkg::*;
  localparam int P = 16;
  logic       clk_in  = 1'b0;
  logic       rst_in  = 1'b1;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       start   = 1'b0;
  logic       lock    = 1'b1;
  logic [7:0] thr     = 8'h02;
  logic [3:0] floor_v = 4'h0;
  logic [3:0] ceil_v  = 4'he;
  aeqc_err_t  err     = '0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [3:0] eq;
  logic [3:0] filt;
  logic [3:0] e0;
  logic [3:0] f0;
  logic       adapting;
  int         err_total = 0;
  int         tests_run = 0;
  int         seed;
  int         i;
  int         k;
  int         n;

  aeqc_top #(.EQ_W(4), .PER_W(16)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .relock_period_in(16'(P)), .error_threshold_in(thr),
    .filter_setting_floor_in(floor_v),
    .filter_setting_ceiling_in(ceil_v), .adapt_start_in(start),
    .lock_in(lock), .link_err_in(err), .eq_setting_out(eq),
    .filter_setting_out(filt), .adapting_out(adapting));

  // Free-running clock, 4 ns period.
  always #2 clk_in = ~clk_in;

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits a number of falling edges, where inputs change.
  task automatic cyc(input int c);
    repeat (c) @(negedge clk_in);
  endtask

  // Register write of one byte.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    cyc(1);
    addr = a;
    wdata = v;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask

  // Register read; data is registered one cycle after the address.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    addr = a;
    cyc(1);
    chk(rdata, exp);
  endtask

  // Programs the control register and launches one adaptation.
  task automatic go(input logic [7:0] ctl);
    wr_reg(8'h42, ctl);
    e0 = eq;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    f0 = filt;
  endtask

  // Waits, bounded, until the sequencer is idle; returns the cycles spent.
  task automatic idle(output int c);
    c = 0;
    while (adapting !== 1'b0 && c < 8 * P) begin
      cyc(1);
      c++;
    end
    chk({7'h0, adapting}, 8'h00);
  endtask

  // First filter value of a sweep for a given order and limits.
  function automatic logic [3:0] first_filt(input logic o,
                                            input logic [3:0] lo,
                                            input logic [3:0] hi);
    if (!o) return hi;
    if (AEQC_FILT_MID < lo) return lo;
    if (AEQC_FILT_MID > hi) return hi;
    return AEQC_FILT_MID;
  endfunction

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    seed = 79948;
    cyc(4);
    rst_in = 1'b0;
    rd(8'h42, AEQC_CTL_RESET);
    rd(8'h43, 8'h00);
    wr_reg(8'h42, 8'hff);
    rd(8'h42, 8'h7f);
    wr_reg(8'h41, 8'h00);
    rd(8'h42, 8'h7f);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr_reg(8'h42, d);
      rd(8'h42, d & 8'h7f);
    end
    // Sweep start and one-step pass timing, random limits.
    for (i = 0; i < 6; i++) begin
      floor_v = 4'($unsigned($random(seed)) % 15);
      k = $unsigned($random(seed)) % (15 - floor_v);
      ceil_v = floor_v + 4'(k);
      go({4'h0, i[0], 3'b001});
      chk({4'h0, filt}, {4'h0, first_filt(i[0], floor_v, ceil_v)});
      idle(n);
      chk({7'h0, n >= P - 1 && n <= P + 2}, 8'h01);
      chk({4'h0, eq}, {4'h0, e0});
    end
    // Failed lock: which setting moves depends on nesting and filter use.
    floor_v = 4'h2;
    ceil_v = 4'hc;
    for (i = 0; i < 3; i++) begin
      lock = 1'b0;
      go({6'h00, i[1], i != 0});
      cyc(P + 3);
      chk({4'h0, eq}, {4'h0, e0 + 4'(i != 2)});
      chk({4'h0, filt}, {4'h0, f0 - 4'(i == 2)});
      lock = 1'b1;
      idle(n);
    end
    // Two-step: an error in the second half advances at once if selected.
    for (i = 0; i < 8; i++) begin
      k = $unsigned($random(seed)) % 3;
      go({1'b0, i[2:0], 4'b0100});
      cyc(P / 2 + 2);
      err = aeqc_err_t'(3'b001 << k);
      cyc(1);
      err = '0;
      cyc(3);
      chk({4'h0, eq}, {4'h0, e0 + 4'(i[k])});
      idle(n);
    end
    // Idle window: errors above threshold raise the equalizer if selected.
    for (i = 0; i < 2; i++) begin
      wr_reg(8'h42, {1'b0, {3{i[0]}}, 4'h0});
      e0 = eq;
      err = 3'b111;
      cyc(P + 4);
      err = '0;
      chk({7'h0, eq != e0}, {7'h0, i[0]});
      idle(n);
    end
    // Reset in mid-adaptation returns every setting to its reset value.
    go(8'h01);
    cyc(3);
    rst_in = 1'b1;
    cyc(4);
    rst_in = 1'b0;
    chk({4'h0, eq}, 8'h00);
    chk({4'h0, filt}, {4'h0, AEQC_FILT_MID});
    chk({7'h0, adapting}, 8'h00);
    rd(8'h42, AEQC_CTL_RESET);
    end_of_test();
  end
endmodule
